// File: design/mws_sequencer.sv
// mode, watchdog and wake-up sequencer with an ahb-lite register slave
// assumes async pins from the supply monitor, bus receiver and host
//
// Summary of operation
// - power-up enters normal-request, main on, secondary off
// - normal-request unwritten 350 ms asserts reset, re-enters
// - watchdog status low during normal-request sequence
// - watchdog write: normal, secondary on, reset high
// - missing refresh in normal resets to normal-request
// - undervoltage with stop selected: reset, interrupt low
// - undervoltage removed restarts in normal-request
// - sleep selected, flag cleared: reset 100 ms
// - after 100 ms enter sleep, regulators off
// - sleep wake edge: main on after 100 us
// - above threshold, reset released within 4 ms
// - third bus pulse wakes, main on 80 us later
// - cyclic sampling 10 us before switch on-time ends
// - cyclic period from register, 5 to 400 ms
// - stop wake edge gives interrupt after 100 us
// - stop third bus pulse gives interrupt after 80 us
// - stop chip-select rise gives interrupt after 60 us
// - stop overcurrent 55 us deglitched, interrupt 60 us
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
module mws_sequencer
    import mws_pkg::*;
#(
    parameter int unsigned NR_TIMEOUT_CYC = `MWS_NR_TIMEOUT_MS * 1000 * `MWS_CLK_MHZ,
    parameter int unsigned RST_SLEEP_CYC  = `MWS_RST_SLEEP_MS * 1000 * `MWS_CLK_MHZ,
    parameter int unsigned RST_DUR_CYC    = `MWS_RST_DUR_MS * 1000 * `MWS_CLK_MHZ,
    parameter int unsigned US_CYC         = `MWS_CLK_MHZ,
    parameter int unsigned MS_CYC         = 1000 * `MWS_CLK_MHZ
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire mws_pins_t   pins,
    output logic             watchdog_status_out_n,
    output logic             reset_out_n,
    output logic             interrupt_out_n,
    output logic             main_reg_en,
    output logic             secondary_regulator,
    output logic             high_side_switch,
    output logic             irq
);
    localparam int unsigned LX_CYC   = `MWS_LX_WAKE_US * US_CYC;
    localparam int unsigned BUS_CYC  = `MWS_BUS_WAKE_US * US_CYC;
    localparam int unsigned CS_CYC   = `MWS_CS_WAKE_US * US_CYC;
    localparam int unsigned DG_CYC   = `MWS_OC_DGLT_US * US_CYC;
    localparam int unsigned OC_CYC   = `MWS_OC_WAKE_US * US_CYC;
    localparam int unsigned HS_CYC   = `MWS_HS_ON_US * US_CYC;
    localparam int unsigned SMP_CYC  = `MWS_CYC_SAMPLE_US * US_CYC;
    localparam int unsigned PLS_CYC  = `MWS_INT_PULSE_US * US_CYC;

    if (US_CYC < 1 || HS_CYC <= SMP_CYC || NR_TIMEOUT_CYC < 2 || RST_SLEEP_CYC < 2) begin : g_chk
        $error("mws_sequencer: timing parameters out of range");
    end

    // cyclic period table in ms, 5 to 400
    function automatic logic [31:0] cyc_ms(input logic [2:0] sel);
        case (sel)
            3'h0: cyc_ms = 32'h0000_0005;
            3'h1: cyc_ms = 32'h0000_000A;
            3'h2: cyc_ms = 32'h0000_0014;
            3'h3: cyc_ms = 32'h0000_0028;
            3'h4: cyc_ms = 32'h0000_004B;
            3'h5: cyc_ms = 32'h0000_0064;
            3'h6: cyc_ms = 32'h0000_00C8;
            default: cyc_ms = 32'h0000_0190;
        endcase
    endfunction

    typedef struct packed {
        mws_pins_t   s1;
        mws_pins_t   s2;
        mws_pins_t   s3;
        mws_mode_t   mode;
        mws_src_t    src;
        logic [31:0] tmr;
        logic [31:0] wdt;
        logic [31:0] cyc;
        logic [31:0] dgl;
        logic [1:0]  bus_cnt;
        logic        pend;
        logic        oc_pend;
        logic [2:0]  wdt_sel;
        logic [2:0]  cyc_sel;
        logic        stop_sel;
        logic        battery_fail_flag;
        logic        cyc_en;
        logic        lx_sense;
        logic [5:0]  irq_stat;
        logic [5:0]  irq_mask;
        logic        d_act;
        logic        d_wr;
        logic [11:0] d_addr;
        logic [31:0] rdata;
        mws_outs_t   o;
        logic        irq;
        logic        int_n;
    } mws_state_t;

    mws_state_t st_reg;
    mws_state_t st_next;

    logic        lx_rise;
    logic        bus_rise;
    logic        cs_rise;
    logic [31:0] wdt_len;
    logic [31:0] cyc_len;
    logic        sample;
    logic [5:0]  ev;
    logic        rd_stat;

    assign lx_rise  = |(st_reg.s2.wake_input & ~st_reg.s3.wake_input);
    assign bus_rise = st_reg.s2.bus_pulse & ~st_reg.s3.bus_pulse;
    assign cs_rise  = st_reg.s2.cs_n & ~st_reg.s3.cs_n;
    assign wdt_len  = cyc_ms({st_reg.wdt_sel}) * 32'(MS_CYC) * 32'h0000_0002;
    assign cyc_len  = cyc_ms(st_reg.cyc_sel) * 32'(MS_CYC);
    assign sample   = st_reg.cyc_en && st_reg.cyc == 32'(HS_CYC) - 32'(SMP_CYC);

    always_comb begin
        st_next = st_reg;
        ev      = '0;
        rd_stat = 1'b0;
        st_next.s1 = pins;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.tmr = st_reg.tmr + 32'h0000_0001;
        st_next.o.irq_out = 1'b0;
        // cyclic high-side switch: on for the first part of each period
        if (st_reg.cyc_en && (st_reg.mode == MWS_SLEEP || st_reg.mode == MWS_STOP)) begin
            st_next.cyc = (st_reg.cyc >= cyc_len - 32'h0000_0001) ? '0 : st_reg.cyc + 32'h0000_0001;
            st_next.o.hs_en = st_reg.cyc < 32'(HS_CYC);
        end else begin
            st_next.cyc = '0;
            st_next.o.hs_en = 1'b0;
        end
        // bus wake pulse counting
        if (bus_rise && (st_reg.mode == MWS_SLEEP || st_reg.mode == MWS_STOP))
            st_next.bus_cnt = st_reg.bus_cnt + 2'h1;
        // overcurrent deglitch
        if (st_reg.s2.main_oc)
            st_next.dgl = (st_reg.dgl < 32'(DG_CYC)) ? st_reg.dgl + 32'h0000_0001 : st_reg.dgl;
        else
            st_next.dgl = '0;

        case (st_reg.mode)
            MWS_NORM_REQ: begin
                st_next.o.wake_out_n  = 1'b0;
                st_next.o.main_reg_en = 1'b1;
                st_next.o.sec_reg_en  = 1'b0;
                st_next.o.reset_out_n = 1'b1;
                if (st_reg.tmr >= NR_TIMEOUT_CYC - 1) begin
                    st_next.o.reset_out_n = 1'b0;
                    st_next.tmr = '0;
                    ev[0] = 1'b1;
                end else if (st_reg.tmr > 32'(PLS_CYC)) begin
                    st_next.o.reset_out_n = 1'b1;
                end else begin
                    st_next.o.reset_out_n = st_reg.o.reset_out_n;
                end
            end
            MWS_NORMAL: begin
                st_next.wdt = st_reg.wdt + 32'h0000_0001;
                if (st_reg.wdt >= wdt_len) begin
                    st_next.mode = MWS_NORM_REQ;
                    st_next.tmr = '0;
                    st_next.o.reset_out_n = 1'b0;
                    st_next.o.sec_reg_en = 1'b0;
                    ev[0] = 1'b1;
                end
            end
            MWS_RESET: begin
                st_next.o.reset_out_n = 1'b0;
                st_next.o.wake_out_n  = 1'b1;
                if (st_reg.stop_sel) begin
                    if (!st_reg.s2.main_uv) begin
                        st_next.mode = MWS_NORM_REQ;
                        st_next.tmr = '0;
                    end
                end else if (st_reg.tmr >= RST_SLEEP_CYC - 1) begin
                    st_next.mode = MWS_SLEEP;
                    st_next.o.main_reg_en = 1'b0;
                    st_next.o.sec_reg_en  = 1'b0;
                    st_next.bus_cnt = '0;
                    st_next.pend = 1'b0;
                end
            end
            MWS_SLEEP, MWS_STOP: begin
                if (!st_reg.pend && !st_reg.oc_pend) begin
                    st_next.tmr = '0;
                    if (st_reg.cyc_en ? (sample && |st_reg.s2.wake_input) : lx_rise) begin
                        st_next.pend = 1'b1;
                        st_next.src = MWS_SRC_LX;
                    end else if (bus_rise && st_reg.bus_cnt == 2'h2) begin
                        st_next.pend = 1'b1;
                        st_next.src = MWS_SRC_BUS;
                    end else if (cs_rise && st_reg.mode == MWS_STOP) begin
                        st_next.pend = 1'b1;
                        st_next.src = MWS_SRC_CS;
                    end
                end else if ((st_reg.src == MWS_SRC_LX && st_reg.tmr >= LX_CYC - 1)
                          || (st_reg.src == MWS_SRC_BUS && st_reg.tmr >= BUS_CYC - 1)
                          || (st_reg.src == MWS_SRC_CS && st_reg.tmr >= CS_CYC - 1)) begin
                    st_next.pend = 1'b0;
                    st_next.tmr = '0;
                    ev[1] = 1'b1;
                    if (st_reg.mode == MWS_SLEEP) begin
                        st_next.mode = MWS_WAKE_RAMP;
                        st_next.o.main_reg_en = 1'b1;
                    end else begin
                        st_next.mode = MWS_NORMAL;
                        st_next.o.irq_out = 1'b1;
                        st_next.wdt = '0;
                    end
                end
                if (st_reg.mode == MWS_STOP && !st_reg.oc_pend && st_reg.dgl == 32'(DG_CYC) - 1) begin
                    st_next.oc_pend = 1'b1;
                    st_next.tmr = '0;
                    st_next.pend = 1'b0;
                end
                if (st_reg.oc_pend && st_reg.tmr >= OC_CYC - 1) begin
                    st_next.oc_pend = 1'b0;
                    st_next.mode = MWS_NORMAL;
                    st_next.o.irq_out = 1'b1;
                    st_next.wdt = '0;
                    ev[1] = 1'b1;
                end
            end
            MWS_WAKE_RAMP: begin
                st_next.tmr = '0;
                if (!st_reg.s2.main_uv)
                    st_next.mode = MWS_WAKE_RST;
            end
            default: begin
                if (st_reg.tmr >= RST_DUR_CYC - 1) begin
                    st_next.mode = MWS_NORM_REQ;
                    st_next.o.reset_out_n = 1'b1;
                    st_next.tmr = '0;
                end
            end
        endcase

        // main regulator undervoltage in normal-request and normal modes only
        if (st_reg.s2.main_uv && (st_reg.mode == MWS_NORM_REQ || st_reg.mode == MWS_NORMAL)
            && (st_reg.stop_sel || !st_reg.battery_fail_flag)) begin
            st_next.mode = MWS_RESET;
            st_next.tmr = '0;
            st_next.o.reset_out_n = 1'b0;
            st_next.o.wake_out_n = 1'b1;
            st_next.o.sec_reg_en = 1'b0;
            ev[2] = 1'b1;
        end
        if (st_reg.s2.main_oc) ev[3] = 1'b1;

        // ahb-lite data phase
        st_next.d_act = hsel && hready && htrans[1];
        st_next.d_wr = hwrite;
        st_next.d_addr = haddr;
        if (st_reg.d_act && st_reg.d_wr) begin
            if (st_reg.d_addr == `MWS_ADDR_CTRL) begin
                st_next.stop_sel = hwdata[0];
                st_next.cyc_en   = hwdata[1];
                st_next.lx_sense = hwdata[2];
                if (hwdata[3]) st_next.battery_fail_flag = 1'b0;
                if (hwdata[4] && st_reg.mode == MWS_NORMAL) begin
                    st_next.mode = st_reg.stop_sel ? MWS_STOP : MWS_RESET;
                    st_next.tmr = '0;
                    st_next.bus_cnt = '0;
                    st_next.o.sec_reg_en = 1'b0;
                    if (!st_reg.stop_sel) st_next.o.reset_out_n = 1'b0;
                end
            end else if (st_reg.d_addr == `MWS_ADDR_WDT) begin
                st_next.wdt_sel = hwdata[2:0];
                st_next.wdt = '0;
                if (st_reg.mode == MWS_NORM_REQ) begin
                    st_next.mode = MWS_NORMAL;
                    st_next.o.sec_reg_en  = 1'b1;
                    st_next.o.wake_out_n  = 1'b1;
                    st_next.o.reset_out_n = 1'b1;
                end
            end else if (st_reg.d_addr == `MWS_ADDR_CYC) begin
                st_next.cyc_sel = hwdata[2:0];
            end else if (st_reg.d_addr == `MWS_ADDR_MASK) begin
                st_next.irq_mask = hwdata[5:0];
            end
        end
        st_next.rdata = '0;
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr == `MWS_ADDR_CTRL)
                st_next.rdata = {27'h0, 1'b0, st_reg.battery_fail_flag, st_reg.lx_sense,
                                 st_reg.cyc_en, st_reg.stop_sel};
            else if (haddr == `MWS_ADDR_WDT)
                st_next.rdata = {29'h0, st_reg.wdt_sel};
            else if (haddr == `MWS_ADDR_CYC)
                st_next.rdata = {29'h0, st_reg.cyc_sel};
            else if (haddr == `MWS_ADDR_STAT)
                st_next.rdata = {24'h0, st_reg.bus_cnt, st_reg.s2.main_oc, st_reg.s2.main_uv,
                                 st_reg.pend, st_reg.mode};
            else if (haddr == `MWS_ADDR_IRQ) begin
                st_next.rdata = {26'h0, st_reg.irq_stat};
                rd_stat = 1'b1;
            end else if (haddr == `MWS_ADDR_MASK)
                st_next.rdata = {26'h0, st_reg.irq_mask};
            else if (haddr == `MWS_ADDR_MODE)
                st_next.rdata = {29'h0, st_reg.mode};
        end
        ev[4] = st_reg.mode == MWS_WAKE_RST && st_next.mode == MWS_NORM_REQ;
        ev[5] = sample;
        // set wins over read-clear
        st_next.irq_stat = (rd_stat ? 6'h00 : st_reg.irq_stat) | ev;
        st_next.irq = |(st_next.irq_stat & st_reg.irq_mask);
        st_next.int_n = !(st_next.o.irq_out || st_next.mode == MWS_RESET);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
            st_reg.mode <= MWS_NORM_REQ;
            st_reg.battery_fail_flag <= 1'b1;
            st_reg.s1.cs_n <= 1'b1;
            st_reg.s2.cs_n <= 1'b1;
            st_reg.s3.cs_n <= 1'b1;
            st_reg.o.reset_out_n <= 1'b0;
            st_reg.o.main_reg_en <= 1'b1;
            st_reg.int_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hrdata                = st_reg.rdata;
    assign hreadyout             = 1'b1;
    assign hresp                 = 1'b0;
    assign watchdog_status_out_n = st_reg.o.wake_out_n;
    assign reset_out_n           = st_reg.o.reset_out_n;
    assign interrupt_out_n       = st_reg.int_n;
    assign main_reg_en           = st_reg.o.main_reg_en;
    assign secondary_regulator   = st_reg.o.sec_reg_en;
    assign high_side_switch      = st_reg.o.hs_en;
    assign irq                   = st_reg.irq;

    wdog_nr_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg.mode == MWS_NORM_REQ && $past(st_reg.mode) == MWS_NORM_REQ
        |-> !watchdog_status_out_n) else $error("watchdog status not low");
    wdt_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(st_reg.mode) == MWS_NORM_REQ && st_reg.mode == MWS_NORMAL
        |-> secondary_regulator && reset_out_n) else $error("normal entry wrong");
    uv_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg.mode == MWS_RESET |=> !reset_out_n || st_reg.mode != MWS_RESET)
        else $error("reset not held");
    sleep_regs_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st_reg.mode == MWS_SLEEP) |-> !main_reg_en && !secondary_regulator)
        else $error("regulators on in sleep");
    reset_int_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg.mode == MWS_RESET |-> !interrupt_out_n) else $error("int not low");
    stop_wake_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(st_reg.mode) == MWS_STOP && st_reg.mode == MWS_NORMAL |-> !interrupt_out_n)
        else $error("no stop wake pulse");
    nr_to_normal_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg.mode == MWS_NORMAL |-> watchdog_status_out_n) else $error("status low");
    oc_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st_reg.oc_pend) |-> st_reg.mode == MWS_STOP) else $error("oc outside stop");
endmodule

// File: design/mws_consts.svh
// constants for the mode, watchdog and wake-up sequencer
// assumes a 25 MHz hclk; times are ms or us as named, counts derived
`ifndef MWS_CONSTS_SVH
`define MWS_CONSTS_SVH
`define MWS_CLK_MHZ            25
`define MWS_NR_TIMEOUT_MS      350
`define MWS_RST_SLEEP_MS       100
`define MWS_LX_WAKE_US         100
`define MWS_BUS_WAKE_US        80
`define MWS_CS_WAKE_US         60
`define MWS_OC_DGLT_US         55
`define MWS_OC_WAKE_US         60
`define MWS_RST_DUR_MS         4
`define MWS_CYC_SAMPLE_US      10
`define MWS_HS_ON_US           200
`define MWS_INT_PULSE_US       4
`define MWS_BUS_WAKE_PULSES    3
`define MWS_ADDR_CTRL          12'h000
`define MWS_ADDR_WDT           12'h004
`define MWS_ADDR_CYC           12'h008
`define MWS_ADDR_STAT          12'h00C
`define MWS_ADDR_IRQ           12'h010
`define MWS_ADDR_MASK          12'h014
`define MWS_ADDR_MODE          12'h018
`define MWS_IRQ_BITS           6
`endif

// File: design/mws_pkg.sv
// types of the mode, watchdog and wake-up sequencer
// assumes mws_consts.svh is on the include path
package mws_pkg;
    `include "mws_consts.svh"
    typedef enum logic [2:0] {
        MWS_NORM_REQ,
        MWS_NORMAL,
        MWS_RESET,
        MWS_SLEEP,
        MWS_WAKE_RAMP,
        MWS_WAKE_RST,
        MWS_STOP
    } mws_mode_t;
    typedef enum logic [1:0] {
        MWS_SRC_NONE,
        MWS_SRC_LX,
        MWS_SRC_BUS,
        MWS_SRC_CS
    } mws_src_t;
    typedef struct packed {
        logic [1:0] wake_input;
        logic       bus_pulse;
        logic       cs_n;
        logic       main_uv;
        logic       main_oc;
    } mws_pins_t;
    typedef struct packed {
        logic        wake_out_n;
        logic        reset_out_n;
        logic        irq_out;
        logic        main_reg_en;
        logic        sec_reg_en;
        logic        hs_en;
    } mws_outs_t;
endpackage

// File: dv/mws_host_model.sv
// host model: ahb-lite master for the sequencer registers, plus chip select
// assumes a single slave whose hreadyout is looped back as hready
`timescale 1ns/10ps
module mws_host_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [11:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata,
    output logic             cs_n
);
    `include "mws_consts.svh"
    initial begin
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        cs_n = 1'b1;
    end
    // one single word transfer, each phase held until hready is seen high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        hwdata <= ~d;
    endtask
    // watchdog write: leaves normal-request, or refreshes in normal
    task automatic kick();
        logic [31:0] q;
        xfer(1'b1, `MWS_ADDR_WDT, 32'h0000_0001, q);
    endtask
    task automatic cs_edge();
        @(posedge hclk);
        cs_n <= 1'b0;
        repeat (3) @(posedge hclk);
        cs_n <= 1'b1;
    endtask
endmodule

// File: dv/mws_sequencer_tb.sv
// self-checking bench for mws_sequencer with shortened timing parameters
// assumes the host model drives the register bus and the chip select
`timescale 1ns/10ps
module mws_sequencer_tb
    import mws_pkg::*;
;
    `include "mws_consts.svh"
    localparam int US = 2;
    localparam int MS = 20;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, cs_n;
    logic        watchdog_status_out_n, reset_out_n, interrupt_out_n, irq;
    logic        main_reg_en, secondary_regulator, high_side_switch;
    logic        bus, uv, oc;
    logic [1:0]  wake, htrans;
    logic [2:0]  hsize;
    logic [11:0] haddr;
    logic [31:0] hwdata, hrdata, q;
    mws_pins_t   pins;
    int          failures, cmp_count, cyc, n, m;
    int          dly[4] = '{100, 80, 60, 115};
    assign pins = '{wake, bus, cs_n, uv, oc};
    mws_sequencer #(.NR_TIMEOUT_CYC(200), .RST_SLEEP_CYC(100), .RST_DUR_CYC(40),
                    .US_CYC(US), .MS_CYC(MS)) u_mws_sequencer (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
        .watchdog_status_out_n(watchdog_status_out_n), .reset_out_n(reset_out_n),
        .interrupt_out_n(interrupt_out_n), .main_reg_en(main_reg_en),
        .secondary_regulator(secondary_regulator), .high_side_switch(high_side_switch),
        .irq(irq));
    mws_host_model u_mws_host_model (
        .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .cs_n(cs_n));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    task automatic conclude();
        if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 80000) begin
            failures++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] win(int v, int d);
        return 32'(v >= d - 6 && v <= d + 8);
    endfunction
    function automatic bit cnd(int k);
        bit [9:0] c;
        c = {watchdog_status_out_n === 1'b0, reset_out_n === 1'b0, high_side_switch === 1'b0,
             secondary_regulator === 1'b0, main_reg_en === 1'b0, high_side_switch === 1'b1,
             reset_out_n === 1'b1, main_reg_en === 1'b1, interrupt_out_n === 1'b0, irq === 1'b1};
        return c[k];
    endfunction
    // counts falling edges until the chosen condition holds or the bound runs out
    task automatic wt(input int k, input int mx, output int c);
        c = 0;
        do begin
            @(negedge hclk);
            c++;
        end while (!cnd(k) && c < mx);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_mws_host_model.xfer(1'b1, a, d, q);
    endtask
    task automatic mode_is(input mws_mode_t e);
        u_mws_host_model.xfer(1'b0, `MWS_ADDR_MODE, 32'h0, q);
        chk(q, {29'h0, e});
        chk({hresp, hreadyout}, 2'b01);
    endtask
    task automatic rst();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask
    task automatic bump(input int c);
        @(posedge hclk);
        repeat (c) begin
            bus <= 1'b1;
            repeat (3) @(posedge hclk);
            bus <= 1'b0;
            repeat (3) @(posedge hclk);
        end
    endtask
    task automatic s_nr_timeout();
        rst();
        u_mws_host_model.xfer(1'b0, `MWS_ADDR_IRQ, 32'h0, q);
        wr(`MWS_ADDR_MASK, 32'h0000_0001);
        wt(0, 140, n);
        chk(n, 140);
        wt(0, 100, n);
        chk(32'(n < 100), 1);
        u_mws_host_model.xfer(1'b0, `MWS_ADDR_IRQ, 32'h0, q);
        chk(q[0], 1'b1);
        chk(irq, 1'b0);
        mode_is(MWS_NORM_REQ);
    endtask
    task automatic s_normal();
        rst();
        u_mws_host_model.kick();
        mode_is(MWS_NORMAL);
        chk({secondary_regulator, watchdog_status_out_n, reset_out_n}, 3'b111);
        wt(6, 30000, n);
        chk(win(n, 2 * 10 * MS), 1);
        mode_is(MWS_NORM_REQ);
        chk(watchdog_status_out_n, 1'b0);
    endtask
    task automatic s_stop_uv();
        rst();
        u_mws_host_model.kick();
        wr(`MWS_ADDR_CTRL, 32'h0000_0001);
        uv <= 1'b1;
        wt(8, 20, n);
        chk({reset_out_n, interrupt_out_n, watchdog_status_out_n}, 3'b001);
        mode_is(MWS_RESET);
        uv <= 1'b0;
        wt(9, 200, n);
        chk(32'(n < 200), 1);
        mode_is(MWS_NORM_REQ);
    endtask
    task automatic s_sleep(input bit by_bus);
        rst();
        u_mws_host_model.kick();
        wr(`MWS_ADDR_CTRL, 32'h0000_0008);
        uv <= 1'b1;
        wt(8, 20, n);
        chk({reset_out_n, interrupt_out_n}, 2'b00);
        wt(5, 300, m);
        chk(win(n + m, 100), 1);
        chk(secondary_regulator, 1'b0);
        mode_is(MWS_SLEEP);
        if (by_bus) begin
            bump(2);
            wt(2, 250, n);
            chk(n, 250);
            bump(1);
        end else begin
            @(posedge hclk);
            wake <= 2'b01;
        end
        wt(2, 400, n);
        chk(win(n, (by_bus ? 80 : 100) * US), 1);
        @(posedge hclk);
        uv <= 1'b0;
        wt(3, 200, n);
        chk(32'(n <= 44), 1);
        @(posedge hclk);
        wake <= 2'b00;
    endtask
    task automatic s_stop();
        for (int k = 0; k < 4; k++) begin
            rst();
            u_mws_host_model.kick();
            wr(`MWS_ADDR_CTRL, 32'h0000_0001);
            wr(`MWS_ADDR_CTRL, 32'h0000_0011);
            mode_is(MWS_STOP);
            @(posedge hclk);
            if (k == 0) wake <= 2'b10;
            if (k == 1) bump(3);
            if (k == 2) u_mws_host_model.cs_edge();
            if (k == 3) oc <= 1'b1;
            wt(1, 400, n);
            chk(win(n, dly[k] * US), 1);
            @(posedge hclk);
            wake <= 2'b00;
            oc <= 1'b0;
            mode_is(MWS_NORMAL);
        end
    endtask
    task automatic s_powerup();
        rst();
        chk({watchdog_status_out_n, main_reg_en, secondary_regulator}, 3'b010);
        mode_is(MWS_NORM_REQ);
    endtask
    task automatic s_cyclic();
        rst();
        u_mws_host_model.kick();
        wr(`MWS_ADDR_CYC, 32'h0000_0003);
        wr(`MWS_ADDR_CTRL, 32'h0000_0003);
        wr(`MWS_ADDR_CTRL, 32'h0000_0013);
        wt(4, 2000, n);
        wt(7, 2000, n);
        chk(win(n, 200 * US), 1);
        wt(4, 2000, m);
        chk(win(n + m, 40 * MS), 1);
        @(posedge hclk);
        wake <= 2'b01;
        wt(1, 2000, n);
        chk(win(n, (200 - 10 + 100) * US), 1);
    endtask
    initial begin
        hresetn = 1'b0;
        wake = 2'b00;
        bus = 1'b0;
        uv = 1'b0;
        oc = 1'b0;
        failures = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        s_nr_timeout();
        s_normal();
        s_stop_uv();
        s_sleep(1'b0);
        s_sleep(1'b1);
        s_stop();
        s_powerup();
        s_cyclic();
        conclude();
    end
endmodule
